// ### design/spsa_params.svh
// Offsets, field positions, receive load values and timing counts of the serial port
`ifndef SPSA_PARAMS_SVH
`define SPSA_PARAMS_SVH
`define SPSA_AW          4
`define SPSA_A_CTRL      4'h0
`define SPSA_A_BUF       4'h4
`define SPSA_A_STAT      4'h8
`define SPSA_CB_MODE     0
`define SPSA_CB_REN      1
`define SPSA_CB_MP       2
`define SPSA_CB_RDBL     3
`define SPSA_CB_TSEL     4
`define SPSA_CB_RSEL     5
`define SPSA_CB_RI       6
`define SPSA_CB_TI       7
`define SPSA_CB_RB8      8
`define SPSA_RESP_OK     2'h0
`define SPSA_RESP_ERR    2'h2
`define SPSA_PH_S1P1     4'h0
`define SPSA_PH_S3P1     4'h4
`define SPSA_PH_S5P2     4'h9
`define SPSA_PH_S6P1     4'ha
`define SPSA_PH_S6P2     4'hb
`define SPSA_PH_LAST     4'hb
`define SPSA_DIV_LAST    4'hf
`define SPSA_SMP7        4'h6
`define SPSA_SMP8        4'h7
`define SPSA_SMP9        4'h8
`define SPSA_TX_DONE_POS 8'h01
`define SPSA_M0_RX_INIT  9'h1fe
`define SPSA_AS_RX_INIT  9'h1ff
`define SPSA_NSYNC       3
`define SPSA_SY_RXD      0
`define SPSA_SY_T1       1
`define SPSA_SY_T2       2
`endif

// ### design/spsa_pkg.sv
// Types of the serial port: receive states and the state records
`include "spsa_params.svh"
package spsa_pkg;
    typedef enum logic [2:0] {
        SPSA_RX_IDLE  = 3'b001,
        SPSA_RX_SHIFT = 3'b010,
        SPSA_RX_ASYNC = 3'b100
    } spsa_rx_state_t;

    typedef struct packed {
        logic [`SPSA_NSYNC-1:0] s1;
        logic [`SPSA_NSYNC-1:0] s2;
        logic [`SPSA_NSYNC-1:0] s3;
    } spsa_sync_t;

    typedef struct packed {
        logic [3:0]     ph;
        logic           mode;
        logic           ren;
        logic           mp;
        logic           rdbl;
        logic           tsel;
        logic           rsel;
        logic           ri;
        logic           ti;
        logic           rb8;
        logic [7:0]     rbuf;
        logic [8:0]     tsh;
        logic           treq;
        logic           tarm;
        logic           tstart;
        logic           send;
        logic           tdat;
        logic           tlast;
        logic [3:0]     tdiv;
        logic           t1h;
        logic [8:0]     rsh;
        spsa_rx_state_t rst;
        logic           rpend;
        logic           rarm;
        logic           rlast;
        logic           rsmp;
        logic           first;
        logic           s7;
        logic           s8;
        logic [3:0]     rdiv;
        logic           txd;
        logic           aw_ok;
        logic           w_ok;
        logic [3:0]     awa;
        logic [31:0]    wd;
        logic           wbe;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } spsa_state_t;
endpackage

// ### design/spsa_sync_edge.sv
// Two-stage synchronisers with edge detection for the pin and timer inputs
`timescale 1ns/100ps
`include "spsa_params.svh"
module spsa_sync_edge (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`SPSA_NSYNC-1:0] raw,
    output logic      [`SPSA_NSYNC-1:0] level,
    output logic      [`SPSA_NSYNC-1:0] rise,
    output logic      [`SPSA_NSYNC-1:0] fall
);
    import spsa_pkg::*;
    spsa_sync_t r_reg;
    spsa_sync_t r_next;

    // Only s2 and s3 are looked at; s1 may be metastable
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = raw;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `SPSA_NSYNC; i++) begin : g_edge
            assign level[i] = r_reg.s2[i];
            assign rise[i]  = r_reg.s2[i] & ~r_reg.s3[i];
            assign fall[i]  = ~r_reg.s2[i] & r_reg.s3[i];
        end
    endgenerate
endmodule

// ### design/spsa_serial_port.sv
// Serial port with shift-register mode and 10-bit asynchronous mode
`timescale 1ns/100ps
`include "spsa_params.svh"
// Notes on behaviour
// - Shift mode: data both ways on rxd pin, clock on txd, 8 bits LSB first.
// - Shift mode rate is fixed at core clock divided by 12.
// - Shift-mode buffer write loads marker, requests; one machine cycle before send.
// - Sending drives data and clock; clock low S3 to S5, high S6 to S2.
// - Each send cycle shifts transmit register right at S6P2, zero fill.
// - MSB out with marker beside: last shift, drop send, set tx done at S1P1.
// - Receive starts on enable and no rx done, here only with transmitter idle; load 111111110, then receive.
// - While receiving, shift clock toggles at S3P1 and S6P1.
// - Receive shifts left at S6P2, inserting pin value sampled at S5P2.
// - Zero reaches leftmost: load buffer, then clear receive, set rx done.
// - Async frame: start 0, 8 data LSB first, stop 1; stop into ninth bit.
// - Async rate from first timer; second timer may drive tx, rx or both.
// - First timer rate divided by 32, or by 16 when rate doubling is set.
// - Async buffer write loads marker, posts request; start follows a rollover.
// - Send gives start bit; data output one bit later; first shift one later.
// - Zero-fill shifting; last shift drops send, sets tx done at 10th rollover.
// - Receiver samples at 16x; falling edge resets counter and loads 1FFH.
// - Each bit sampled at counter states 7, 8 and 9; majority accepted.
// - Start bit not 0 aborts and hunts again; otherwise shift it in.
// - Frame ends with start leftmost; load only if rx done 0 and mp rule met.
// - Good load: stop to ninth bit, data to buffer, set rx done; hunt again.
module spsa_serial_port (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [`SPSA_AW-1:0]  s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [`SPSA_AW-1:0]  s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 rxd_i,
    output logic                      rxd_o,
    output logic                      rxd_oe,
    output logic                      txd_o,
    input  wire logic                 timer1_ovf,
    input  wire logic                 timer2_ovf
);
    import spsa_pkg::*;

    spsa_state_t            r_reg;
    spsa_state_t            r_next;
    logic [`SPSA_NSYNC-1:0] sy_lvl;
    logic [`SPSA_NSYNC-1:0] sy_rise;
    logic [`SPSA_NSYNC-1:0] sy_fall;

    ////////////////////////////////////////////////////////////////////////////
    spsa_sync_edge u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({timer2_ovf, timer1_ovf, rxd_i}),
        .level   (sy_lvl),
        .rise    (sy_rise),
        .fall    (sy_fall)
    );

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] o;
        for (int i = 0; i < 8; i++) begin
            o[i] = v[7-i];
        end
        return o;
    endfunction

    function automatic logic lowph(input logic [3:0] p);
        return (p >= `SPSA_PH_S3P1) && (p < `SPSA_PH_S6P1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic       pin;
    logic       t1_tick;
    logic       tx_tick;
    logic       rx_tick;
    logic       tx_roll;
    logic       do_wr;
    logic       wr_ctrl;
    logic       wr_buf;
    logic       ti_set;
    logic       ri_set;
    logic       bitv;
    logic       rx_idle;
    logic [8:0] nsh;

    always_comb begin
        r_next  = r_reg;
        pin     = sy_lvl[`SPSA_SY_RXD];
        ti_set  = 1'b0;
        ri_set  = 1'b0;
        bitv    = 1'b0;
        nsh     = r_reg.rsh;
        rx_idle = (r_reg.rst == SPSA_RX_IDLE);

        // Machine cycle of 12 core clocks: S1P1 .. S6P2
        r_next.ph = (r_reg.ph == `SPSA_PH_LAST) ? `SPSA_PH_S1P1 : 4'(r_reg.ph + 4'h1);

        // 16x ticks: timer 1 halved unless doubled, or timer 2 directly
        if (sy_rise[`SPSA_SY_T1]) begin
            r_next.t1h = ~r_reg.t1h;
        end
        t1_tick = sy_rise[`SPSA_SY_T1] & (r_reg.rdbl | r_reg.t1h);
        tx_tick = r_reg.tsel ? sy_rise[`SPSA_SY_T2] : t1_tick;
        rx_tick = r_reg.rsel ? sy_rise[`SPSA_SY_T2] : t1_tick;
        if (tx_tick) begin
            r_next.tdiv = 4'(r_reg.tdiv + 4'h1);
        end
        tx_roll = tx_tick & (r_reg.tdiv == `SPSA_DIV_LAST);

        ////////////////////////////////////////////////////////////////////////
        // Register bus: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_ok = 1'b1;
            r_next.awa   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_ok = 1'b1;
            r_next.wd   = s_axi_wdata;
            r_next.wbe  = s_axi_wstrb[0];
        end
        do_wr   = r_reg.aw_ok & r_reg.w_ok & ~r_reg.bvalid;
        wr_ctrl = do_wr & r_reg.wbe & (r_reg.awa == `SPSA_A_CTRL);
        wr_buf  = do_wr & r_reg.wbe & (r_reg.awa == `SPSA_A_BUF);
        if (do_wr) begin
            r_next.aw_ok  = 1'b0;
            r_next.w_ok   = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = (r_reg.awa == `SPSA_A_CTRL || r_reg.awa == `SPSA_A_BUF)
                            ? `SPSA_RESP_OK : `SPSA_RESP_ERR;
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = `SPSA_RESP_OK;
            case (s_axi_araddr)
                `SPSA_A_CTRL: r_next.rdata = {23'h0, r_reg.rb8, r_reg.ti, r_reg.ri, r_reg.rsel, r_reg.tsel,
                                              r_reg.rdbl, r_reg.mp, r_reg.ren, r_reg.mode};
                `SPSA_A_BUF:  r_next.rdata = {24'h0, r_reg.rbuf};
                `SPSA_A_STAT: r_next.rdata = {29'h0, r_reg.treq | r_reg.tarm | r_reg.tstart, ~rx_idle,
                                              r_reg.send};
                default: begin
                    r_next.rdata = 32'h0000_0000;
                    r_next.rresp = `SPSA_RESP_ERR;
                end
            endcase
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Transmitter
        if (!r_reg.mode) begin
            if (r_reg.ph == `SPSA_PH_S1P1) begin
                if (r_reg.tlast) begin
                    r_next.send  = 1'b0;
                    r_next.tlast = 1'b0;
                    ti_set       = 1'b1;
                end else if (r_reg.tarm) begin
                    r_next.tarm = 1'b0;
                    r_next.send = 1'b1;
                end else if (r_reg.treq) begin
                    r_next.treq = 1'b0;
                    r_next.tarm = 1'b1;
                end
            end
            if (r_reg.ph == `SPSA_PH_S6P2 && r_reg.send && !r_reg.tlast) begin
                r_next.tsh = {1'b0, r_reg.tsh[8:1]};
                if (r_reg.tsh[8:1] == `SPSA_TX_DONE_POS) begin
                    r_next.tlast = 1'b1;
                end
            end
        end else begin
            if (tx_roll) begin
                if (r_reg.send) begin
                    if (!r_reg.tdat) begin
                        r_next.tdat = 1'b1;
                    end else begin
                        r_next.tsh = {1'b0, r_reg.tsh[8:1]};
                        if (r_reg.tsh[8:1] == `SPSA_TX_DONE_POS) begin
                            r_next.send = 1'b0;
                            r_next.tdat = 1'b0;
                            ti_set      = 1'b1;
                        end
                    end
                end else if (r_reg.treq) begin
                    r_next.treq   = 1'b0;
                    r_next.tstart = 1'b1;
                end
            end
            if (r_reg.ph == `SPSA_PH_S1P1 && r_reg.tstart) begin
                r_next.tstart = 1'b0;
                r_next.send   = 1'b1;
                r_next.tdat   = 1'b0;
            end
        end
        // A write while busy restarts the frame; software should wait for tx done
        if (wr_buf) begin
            r_next.tsh    = {1'b1, r_reg.wd[7:0]};
            r_next.treq   = 1'b1;
            r_next.tarm   = 1'b0;
            r_next.tstart = 1'b0;
            r_next.send   = 1'b0;
            r_next.tdat   = 1'b0;
            r_next.tlast  = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Receiver
        if (!r_reg.mode) begin
            if (r_reg.ph == `SPSA_PH_S1P1) begin
                if (r_reg.rlast) begin
                    r_next.rlast = 1'b0;
                    r_next.rst   = SPSA_RX_IDLE;
                    ri_set       = 1'b1;
                end else if (r_reg.rarm) begin
                    r_next.rarm = 1'b0;
                    r_next.rst  = SPSA_RX_SHIFT;
                end else if (rx_idle && !r_reg.rpend && r_reg.ren && !r_reg.ri
                             && !r_reg.send && !r_reg.treq && !r_reg.tarm) begin
                    r_next.rpend = 1'b1;
                end
            end
            if (r_reg.ph == `SPSA_PH_S5P2) begin
                r_next.rsmp = pin;
            end
            if (r_reg.ph == `SPSA_PH_S6P2) begin
                if (r_reg.rpend) begin
                    r_next.rpend = 1'b0;
                    r_next.rarm  = 1'b1;
                    r_next.rsh   = `SPSA_M0_RX_INIT;
                end else if (r_reg.rst == SPSA_RX_SHIFT && !r_reg.rlast) begin
                    nsh        = {r_reg.rsh[7:0], r_reg.rsmp};
                    r_next.rsh = nsh;
                    if (!nsh[8]) begin
                        r_next.rbuf  = rev8(nsh[7:0]);
                        r_next.rlast = 1'b1;
                    end
                end
            end
        end else begin
            case (r_reg.rst)
                SPSA_RX_IDLE: begin
                    if (sy_fall[`SPSA_SY_RXD]) begin
                        r_next.rdiv  = 4'h0;
                        r_next.rsh   = `SPSA_AS_RX_INIT;
                        r_next.first = 1'b1;
                        r_next.rst   = SPSA_RX_ASYNC;
                    end
                end
                SPSA_RX_ASYNC: begin
                    if (rx_tick) begin
                        r_next.rdiv = 4'(r_reg.rdiv + 4'h1);
                        if (r_reg.rdiv == `SPSA_SMP7) begin
                            r_next.s7 = pin;
                        end
                        if (r_reg.rdiv == `SPSA_SMP8) begin
                            r_next.s8 = pin;
                        end
                        if (r_reg.rdiv == `SPSA_SMP9) begin
                            // Two of three votes reject short glitches
                            bitv = (r_reg.s7 & r_reg.s8) | (r_reg.s7 & pin) | (r_reg.s8 & pin);
                            if (r_reg.first) begin
                                r_next.first = 1'b0;
                                if (bitv) begin
                                    r_next.rst = SPSA_RX_IDLE;
                                end else begin
                                    r_next.rsh = {r_reg.rsh[7:0], 1'b0};
                                end
                            end else if (!r_reg.rsh[8]) begin
                                // Stop bit arrives: start sits leftmost
                                if (!r_reg.ri && (!r_reg.mp || bitv)) begin
                                    r_next.rbuf = rev8(r_reg.rsh[7:0]);
                                    r_next.rb8  = bitv;
                                    ri_set      = 1'b1;
                                end
                                r_next.rst = SPSA_RX_IDLE;
                            end else begin
                                r_next.rsh = {r_reg.rsh[7:0], bitv};
                            end
                        end
                    end
                end
                default: begin
                    r_next.rst = SPSA_RX_IDLE;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Control writes; a hardware set in the same cycle wins the flag
        if (wr_ctrl) begin
            r_next.mode = r_reg.wd[`SPSA_CB_MODE];
            r_next.ren  = r_reg.wd[`SPSA_CB_REN];
            r_next.mp   = r_reg.wd[`SPSA_CB_MP];
            r_next.rdbl = r_reg.wd[`SPSA_CB_RDBL];
            r_next.tsel = r_reg.wd[`SPSA_CB_TSEL];
            r_next.rsel = r_reg.wd[`SPSA_CB_RSEL];
            r_next.ri   = r_reg.wd[`SPSA_CB_RI];
            r_next.ti   = r_reg.wd[`SPSA_CB_TI];
            if (!ri_set) begin
                r_next.rb8 = r_reg.wd[`SPSA_CB_RB8];
            end
        end
        if (ti_set) begin
            r_next.ti = 1'b1;
        end
        if (ri_set) begin
            r_next.ri = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        // Line drivers, registered against the next state
        if (!r_next.mode) begin
            if (r_next.send || r_next.rst == SPSA_RX_SHIFT) begin
                r_next.txd = ~lowph(r_next.ph);
            end else begin
                r_next.txd = 1'b1;
            end
        end else if (r_next.send) begin
            r_next.txd = r_next.tdat ? r_next.tsh[0] : 1'b0;
        end else begin
            r_next.txd = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg     <= '0;
            r_reg.rst <= SPSA_RX_IDLE;
            r_reg.txd <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = ~r_reg.aw_ok & ~r_reg.bvalid;
    assign s_axi_wready  = ~r_reg.w_ok & ~r_reg.bvalid;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = ~r_reg.rvalid;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rdata   = r_reg.rdata;
    assign s_axi_rresp   = r_reg.rresp;
    assign txd_o         = r_reg.txd;
    assign rxd_o         = r_reg.tsh[0];
    assign rxd_oe        = r_reg.send & ~r_reg.mode;
endmodule

// ### bench/spsa_sva.sv
// Checker of pin timing and bus handshakes of the serial port
`timescale 1ns/100ps
module spsa_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic rxd_o,
    input wire logic rxd_oe,
    input wire logic txd_o
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    property p_lo; $fell(txd_o) && rxd_oe |-> !txd_o [*6] ##1 txd_o; endproperty
    a_lo: assert property (p_lo) else $error("clock low span wrong");
    property p_hi; $rose(txd_o) && rxd_oe |-> txd_o [*6]; endproperty
    a_hi: assert property (p_hi) else $error("clock high span wrong");
    property p_per; $fell(txd_o) && rxd_oe |-> ##12 ($fell(txd_o) || !rxd_oe); endproperty
    a_per: assert property (p_per) else $error("shift period wrong");
    // Data may only move while the clock is high, so the far side samples it safely
    property p_sh; rxd_oe && $past(rxd_oe) && $changed(rxd_o) |-> txd_o; endproperty
    a_sh: assert property (p_sh) else $error("data moved in low phase");
    property p_st; $rose(rxd_oe) |-> txd_o [*3] ##1 !txd_o; endproperty
    a_st: assert property (p_st) else $error("send start misaligned");
    property p_bw; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_bw: assert property (p_bw) else $error("write answer late");
    property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bd: assert property (p_bd) else $error("write answer stuck");
    property p_rv; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rv: assert property (p_rv) else $error("read answer late");
endmodule
bind spsa_serial_port spsa_sva sva_u (.*);

// ### bench/spsa_peer.sv
// Far side: shift-register device and asynchronous serial peer
`timescale 1ns/100ps
module spsa_peer #(
    parameter int BIT_NS = 12800
) (
    input wire logic txd,
    input wire logic pin,
    output logic     drv
);
    logic [7:0] got;
    logic       stop;
    initial drv = 1'b1;
    ////////////////////////////////////////
    task automatic shift_in();
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            got[i] = pin;
        end
    endtask
    // Released line has no pull, so it shows the inverse of the last bit
    task automatic shift_out(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd);
            drv <= b[i];
        end
        @(posedge txd);
        drv <= ~b[7];
    endtask
    task automatic send_async(input logic [7:0] b, input logic s);
        drv <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            #(BIT_NS);
            drv <= (i < 8) ? b[i] : s;
        end
        #(BIT_NS);
        drv <= 1'b1;
    endtask
    task automatic recv_async();
        @(negedge txd);
        #(BIT_NS / 2);
        for (int i = 0; i < 9; i++) begin
            #(BIT_NS);
            if (i < 8) got[i] = txd;
            else stop = txd;
        end
    endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench of the serial port
`timescale 1ns/100ps
`include "spsa_params.svh"
module testbench;
    logic                aclk = 1'b0, aresetn = 1'b0, drv;
    logic [`SPSA_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]         s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0]          s_axi_wstrb = 4'hf;
    logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer1_ovf = 1'b0, timer2_ovf = 1'b0;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]          s_axi_bresp, s_axi_rresp, r;
    logic                rxd_o, rxd_oe, txd_o;
    wire logic           rxd_i;
    logic [7:0]          b, ex;
    logic [7:0]          q[$];
    int                  n_errors = 0, compares = 0;
    int unsigned         seed = 77;
    // Last frame takes its receive rate from the second overflow input
    localparam logic [31:0] CT [4] = '{32'h0000_000b, 32'h0000_004b, 32'h0000_000f, 32'h0000_002f};
    localparam logic [3:0]  ST = 4'hb, LD = 4'h9;
    assign rxd_i = rxd_oe ? rxd_o : drv;
    spsa_serial_port dut_u (.*);
    spsa_peer peer_u (.txd(txd_o), .pin(rxd_i), .drv(drv));
    initial forever #50 aclk = ~aclk;
    // Overflow inputs run free at 16 times the bit rate, out of phase with the core clock
    initial begin #130; forever #400 timer1_ovf = ~timer1_ovf; end
    initial begin #270; forever #400 timer2_ovf = ~timer2_ovf; end
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [3:0] a);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #4000000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        wr(4'hc, 32'h0000_00ff);
        chk(r, `SPSA_RESP_ERR);
        rd(4'hc);
        chk({d[29:0], r}, {30'h0, `SPSA_RESP_ERR});
        for (int k = 0; k < 2; k++) begin
            q.push_back(rnd());
            wr(`SPSA_A_BUF, {24'h0, q[0]});
            peer_u.shift_in();
            chk({24'h0, peer_u.got}, {24'h0, q.pop_front()});
            repeat (4) @(posedge aclk);
            rd(`SPSA_A_CTRL);
            chk(d & 32'h0000_0080, 32'h0000_0080);
            wr(`SPSA_A_CTRL, 32'h0000_0000);
        end
        for (int k = 0; k < 2; k++) begin
            b = rnd();
            wr(`SPSA_A_CTRL, 32'h0000_0002);
            peer_u.shift_out(b);
            repeat (24) @(posedge aclk);
            rd(`SPSA_A_CTRL);
            chk(d & 32'h0000_0040, 32'h0000_0040);
            rd(`SPSA_A_BUF);
            chk(d, {24'h0, b});
        end
        ex = b;
        peer_u.drv <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            b = rnd();
            wr(`SPSA_A_CTRL, k ? 32'h0000_0019 : 32'h0000_0009);
            wr(`SPSA_A_BUF, {24'h0, b});
            peer_u.recv_async();
            chk({23'h0, peer_u.stop, peer_u.got}, {24'h1, b});
            rd(`SPSA_A_CTRL);
            chk(d & 32'h0000_0080, 32'h0000_0080);
        end
        wr(`SPSA_A_CTRL, CT[0]);
        peer_u.drv <= 1'b0;
        #2400 peer_u.drv <= 1'b1;
        repeat (400) @(posedge aclk);
        rd(`SPSA_A_CTRL);
        chk(d & 32'h0000_0040, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(`SPSA_A_CTRL, CT[k]);
            b = rnd();
            peer_u.send_async(b, ST[k]);
            if (LD[k]) ex = b;
            rd(`SPSA_A_BUF);
            chk(d, {24'h0, ex});
            rd(`SPSA_A_CTRL);
            chk(d & 32'h0000_0140, {23'h0, LD[k] & ST[k], 1'b0, LD[k] | CT[k][6], 6'h0});
        end
        rd(`SPSA_A_STAT);
        chk(d, 32'h0000_0000);
        give_verdict();
    end
endmodule
